// ===== common/acg_pkg.sv
// constants, register map and field layout of the audio clock rate generator
// Behaviour
// - converters run from an internal master clock at 256 times reference rate.
// - master clock input 512 kHz to 50 MHz feeds divider or PLL.
// - bit clock pin or second general pin may source the master clock.
// - codec powered down: second general pin through PLL out first general pin.
// - PLL off: reference rate is divider source over 128 times Q, Q 2..17.
// - divider source picked by two-bit field in upper bits of register 102.
// - PLL on: reference is source times K times R over 2048 times P.
// - multiplier integer part 1..63 plus four-digit fraction 0000..9999.
// - DAC rate is reference or double reference over 1..6 in half steps.
// - one reference rate; ADC and DAC divisors programmed independently.
// - reference normally 44.1 or 48 kHz, up to 53 kHz.
// - standard converter rates 8 kHz to 96 kHz are reachable.
// - each partition instantiates its own copy, fully asynchronous rates.
// - differing rates: word clock marks DAC frame, ADC sync on first general pin.
package acg_pkg;
  // register indices; byte address is four times the index
  localparam int unsigned IDX_CTRL    = 96;
  localparam int unsigned IDX_PLL_A   = 97;
  localparam int unsigned IDX_PLL_D   = 98;
  localparam int unsigned IDX_DIV     = 99;
  localparam int unsigned IDX_STATUS  = 100;
  localparam int unsigned IDX_CLK_SRC = 102;
  localparam logic [11:0] ADDR_CTRL    = 12'(IDX_CTRL * 4);
  localparam logic [11:0] ADDR_PLL_A   = 12'(IDX_PLL_A * 4);
  localparam logic [11:0] ADDR_PLL_D   = 12'(IDX_PLL_D * 4);
  localparam logic [11:0] ADDR_DIV     = 12'(IDX_DIV * 4);
  localparam logic [11:0] ADDR_STATUS  = 12'(IDX_STATUS * 4);
  localparam logic [11:0] ADDR_CLK_SRC = 12'(IDX_CLK_SRC * 4);
  // clock source field positions and codes
  localparam int unsigned DIVSRC_LSB = 6;
  localparam int unsigned PLLSRC_LSB = 4;
  localparam logic [1:0] SRC_MCLK = 2'h0;
  localparam logic [1:0] SRC_BCLK = 2'h1;
  localparam logic [1:0] SRC_GIO2 = 2'h2;
  // control bits
  localparam int unsigned CTRL_PLL_EN   = 0;
  localparam int unsigned CTRL_PWR_UP   = 1;
  localparam int unsigned CTRL_DAC_DUAL = 2;
  localparam int unsigned CTRL_ADC_DUAL = 3;
  // pll field layout: p [3:0], r [8:4], j [14:9]
  localparam int unsigned PLL_P_LSB = 0;
  localparam int unsigned PLL_R_LSB = 4;
  localparam int unsigned PLL_J_LSB = 9;
  // divider layout: q [4:0], dac_rate_divisor code [11:8], adc_rate_divisor code [15:12]; code = 2 x divisor
  localparam int unsigned DIV_Q_LSB    = 0;
  localparam int unsigned DIV_DAC_RATE_DIVISOR_LSB = 8;
  localparam int unsigned DIV_ADC_RATE_DIVISOR_LSB = 12;
  // reset values
  localparam logic [7:0]  RST_CLK_SRC = 8'h00;
  localparam logic [3:0]  RST_CTRL    = 4'h0;
  localparam logic [3:0]  RST_P       = 4'h1;
  localparam logic [4:0]  RST_R       = 5'h01;
  localparam logic [5:0]  RST_J       = 6'h08;
  localparam logic [13:0] RST_D       = 14'h0780;
  localparam logic [4:0]  RST_Q       = 5'h02;
  localparam logic [3:0]  RST_NCODE   = 4'h2;
  // legal ranges
  localparam logic [4:0]  Q_MIN = 5'h02;
  localparam logic [4:0]  Q_MAX = 5'h11;
  localparam logic [3:0]  N_MIN = 4'h2;
  localparam logic [3:0]  N_MAX = 4'hc;
  localparam logic [3:0]  P_MIN = 4'h1;
  localparam logic [3:0]  P_MAX = 4'h8;
  localparam logic [4:0]  R_MIN = 5'h01;
  localparam logic [4:0]  R_MAX = 5'h10;
  localparam logic [5:0]  J_MIN = 6'h01;
  localparam logic [5:0]  J_MAX = 6'h3f;
  localparam logic [13:0] D_MAX = 14'h270f;
  // ratios: 256 master ticks per frame, fraction in ten-thousandths
  localparam int unsigned MCLK_PER_FS   = 256;
  localparam logic [31:0] FRAC_SCALE    = 32'h0000_2710;
  // pll: ticks per source edge = K*R*256/(2048*P) = K*R/(8*P)
  localparam logic [31:0] PLL_DEN_SCALE = 32'h0001_3880;
  // frame length in ticks per half divisor step, single and double rate
  localparam logic [10:0] HALF_STEP_SGL = 11'h080;
  localparam logic [10:0] HALF_STEP_DBL = 11'h040;
endpackage

// ===== design/acg_rate_gen.sv
// audio clock rate generator for one codec partition with apb register access
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module acg_rate_gen
  import acg_pkg::*;
#(
  parameter int unsigned SYNC_W = 3
) (
  // system
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // clock pins
  input  wire logic        mclk_pin,
  input  wire logic        bclk_pin,
  input  wire logic        general_io_two_pin,
  // first general pin, two-way
  input  wire logic        general_io_one_in,
  output logic             general_io_one_out,
  output logic             general_io_one_oe,
  // converter timing
  output logic             master_tick,
  output logic             fs_ref_tick,
  output logic             dac_sample_tick,
  output logic             adc_sample_tick,
  output logic             dac_frame_sync,
  output logic             adc_frame_sync
);

  // ---------------- registers ----------------
  // self-contained, one copy per partition
  logic [7:0]  clk_src;
  logic [3:0]  ctrl;
  logic [3:0]  pll_p;
  logic [4:0]  pll_r;
  logic [5:0]  pll_j;
  logic [13:0] pll_d;
  logic [4:0]  div_q;
  logic [3:0]  dac_rate_divisor_code;
  logic [3:0]  adc_rate_divisor_code;
  logic        rates_differ;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_val;

  assign wr_en = psel && penable && pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      ADDR_CLK_SRC: rd_val[7:0] = clk_src;
      ADDR_CTRL:    rd_val[3:0] = ctrl;
      ADDR_PLL_A: begin
        rd_val[PLL_P_LSB +: 4] = pll_p;
        rd_val[PLL_R_LSB +: 5] = pll_r;
        rd_val[PLL_J_LSB +: 6] = pll_j;
      end
      ADDR_PLL_D:   rd_val[13:0] = pll_d;
      ADDR_DIV: begin
        rd_val[DIV_Q_LSB +: 5]    = div_q;
        rd_val[DIV_DAC_RATE_DIVISOR_LSB +: 4] = dac_rate_divisor_code;
        rd_val[DIV_ADC_RATE_DIVISOR_LSB +: 4] = adc_rate_divisor_code;
      end
      ADDR_STATUS:  rd_val[3:0] = {rates_differ, general_io_one_oe, fs_ref_tick, master_tick};
      default:      hit = 1'b0;
    endcase
  end

  // zero wait states: data and error are captured in the setup cycle
  assign pready = 1'b1;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= !hit;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_src <= RST_CLK_SRC;
      ctrl    <= RST_CTRL;
    end else if (wr_en && paddr == ADDR_CLK_SRC) begin
      clk_src <= pwdata[7:0];
    end else if (wr_en && paddr == ADDR_CTRL) begin
      ctrl <= pwdata[3:0];
    end
  end

  // out-of-range values are clamped so the counters never see a zero divisor
  // multiplier fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pll_p <= RST_P;
      pll_r <= RST_R;
      pll_j <= RST_J;
      pll_d <= RST_D;
    end else if (wr_en && paddr == ADDR_PLL_A) begin
      pll_p <= (pwdata[PLL_P_LSB +: 4] < P_MIN) ? P_MIN :
               (pwdata[PLL_P_LSB +: 4] > P_MAX) ? P_MAX : pwdata[PLL_P_LSB +: 4];
      pll_r <= (pwdata[PLL_R_LSB +: 5] < R_MIN) ? R_MIN :
               (pwdata[PLL_R_LSB +: 5] > R_MAX) ? R_MAX : pwdata[PLL_R_LSB +: 5];
      pll_j <= (pwdata[PLL_J_LSB +: 6] < J_MIN) ? J_MIN : pwdata[PLL_J_LSB +: 6];
    end else if (wr_en && paddr == ADDR_PLL_D) begin
      pll_d <= (pwdata[13:0] > D_MAX) ? D_MAX : pwdata[13:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q     <= RST_Q;
      dac_rate_divisor_code <= RST_NCODE;
      adc_rate_divisor_code <= RST_NCODE;
    end else if (wr_en && paddr == ADDR_DIV) begin
      div_q <= (pwdata[DIV_Q_LSB +: 5] < Q_MIN) ? Q_MIN :
               (pwdata[DIV_Q_LSB +: 5] > Q_MAX) ? Q_MAX : pwdata[DIV_Q_LSB +: 5];
      dac_rate_divisor_code <= (pwdata[DIV_DAC_RATE_DIVISOR_LSB +: 4] < N_MIN) ? N_MIN :
                   (pwdata[DIV_DAC_RATE_DIVISOR_LSB +: 4] > N_MAX) ? N_MAX : pwdata[DIV_DAC_RATE_DIVISOR_LSB +: 4];
      adc_rate_divisor_code <= (pwdata[DIV_ADC_RATE_DIVISOR_LSB +: 4] < N_MIN) ? N_MIN :
                   (pwdata[DIV_ADC_RATE_DIVISOR_LSB +: 4] > N_MAX) ? N_MAX : pwdata[DIV_ADC_RATE_DIVISOR_LSB +: 4];
    end
  end

  logic pll_en;
  logic pwr_up;
  assign pll_en = ctrl[CTRL_PLL_EN];
  assign pwr_up = ctrl[CTRL_PWR_UP];

  // ---------------- pin synchronisers ----------------
  // a change is accepted only when the second and third stages agree
  logic [2:0] pin_raw;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_edge;
  assign pin_raw = {general_io_two_pin, bclk_pin, mclk_pin};

  generate
    for (genvar gi = 0; gi < 3; gi++) begin : g_sync
      logic [SYNC_W-1:0] sh;
      logic              prev;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sh         <= '0;
          pin_lvl[gi] <= 1'b0;
          prev       <= 1'b0;
        end else begin
          sh   <= {sh[SYNC_W-2:0], pin_raw[gi]};
          prev <= pin_lvl[gi];
          if (sh[SYNC_W-2] == sh[SYNC_W-1]) begin
            pin_lvl[gi] <= sh[SYNC_W-1];
          end
        end
      end
      assign pin_edge[gi] = pin_lvl[gi] ^ prev;
      assign pin_rise[gi] = pin_lvl[gi] & ~prev;
    end
  endgenerate

  // ---------------- integer divider path ----------------
  // both source edges are counted: q edges give q/2 source cycles per tick,
  // so 256 ticks span 128*q source cycles
  logic [1:0] div_sel;
  logic       div_src_edge;
  logic [4:0] div_cnt;
  logic       div_tick;
  assign div_sel = clk_src[DIVSRC_LSB +: 2];

  always_comb begin
    case (div_sel)
      SRC_BCLK: div_src_edge = pin_edge[1];
      SRC_GIO2: div_src_edge = pin_edge[2];
      default:  div_src_edge = pin_edge[0];
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || pll_en) begin
      div_cnt  <= 5'h00;
      div_tick <= 1'b0;
    end else begin
      div_tick <= 1'b0;
      if (div_src_edge) begin
        if (div_cnt >= div_q - 5'h01) begin
          div_cnt  <= 5'h00;
          div_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 5'h01;
        end
      end
    end
  end

  // ---------------- fractional pll path ----------------
  // rate accumulator: each source rising edge adds (j*10000+d)*r, each tick
  // removes 80000*p; output rate is capped at one tick per system clock
  logic        pll_src_rise;
  logic [31:0] pll_inc;
  logic [31:0] pll_thr;
  logic [31:0] pll_acc;
  logic [31:0] next_pll_acc;
  logic        pll_tick;
  logic        pll_fire;

  // powered down takes the second general pin
  always_comb begin
    if (!pwr_up) begin
      pll_src_rise = pin_rise[2];
    end else if (clk_src[PLLSRC_LSB +: 2] == SRC_BCLK) begin
      pll_src_rise = pin_rise[1];
    end else begin
      pll_src_rise = pin_rise[0];
    end
  end

  assign pll_inc  = 32'((32'(pll_j) * FRAC_SCALE + 32'(pll_d)) * 32'(pll_r));
  assign pll_thr  = 32'(PLL_DEN_SCALE * 32'(pll_p));
  assign pll_fire = pll_acc >= pll_thr;

  always_comb begin
    next_pll_acc = pll_acc;
    if (pll_fire) begin
      next_pll_acc = next_pll_acc - pll_thr;
    end
    if (pll_src_rise) begin
      next_pll_acc = next_pll_acc + pll_inc;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !pll_en) begin
      pll_acc  <= 32'h0000_0000;
      pll_tick <= 1'b0;
    end else begin
      pll_acc  <= next_pll_acc;
      pll_tick <= pll_fire;
    end
  end

  // ---------------- master tick and reference frame ----------------
  logic       conv_tick;
  logic [7:0] frame_cnt;
  // master tick from divider or pll
  assign conv_tick = pwr_up && (pll_en ? pll_tick : div_tick);

  // reference rate follows the programmed ratios
  always_ff @(posedge clk) begin
    if (sys_rst || !pwr_up) begin
      frame_cnt   <= 8'h00;
      master_tick <= 1'b0;
      fs_ref_tick <= 1'b0;
    end else begin
      master_tick <= conv_tick;
      fs_ref_tick <= conv_tick && frame_cnt == 8'(MCLK_PER_FS - 1);
      if (conv_tick) begin
        frame_cnt <= frame_cnt + 8'h01;
      end
    end
  end

  // ---------------- converter rates ----------------
  // frame length in ticks = code * (128 or 64): code/2 divisor, double rate halves it
  logic [10:0] dac_len;
  logic [10:0] adc_len;
  logic [10:0] dac_cnt;
  logic [10:0] adc_cnt;
  assign dac_len = 11'(dac_rate_divisor_code * (ctrl[CTRL_DAC_DUAL] ? HALF_STEP_DBL : HALF_STEP_SGL));
  assign adc_len = 11'(adc_rate_divisor_code * (ctrl[CTRL_ADC_DUAL] ? HALF_STEP_DBL : HALF_STEP_SGL));
  assign rates_differ = dac_len != adc_len;

  // rates 8 to 96 kHz from these divisors
  always_ff @(posedge clk) begin
    if (sys_rst || !pwr_up) begin
      dac_cnt         <= 11'h000;
      dac_sample_tick <= 1'b0;
    end else begin
      dac_sample_tick <= 1'b0;
      if (conv_tick) begin
        if (dac_cnt >= dac_len - 11'h001) begin
          dac_cnt         <= 11'h000;
          dac_sample_tick <= 1'b1;
        end else begin
          dac_cnt <= dac_cnt + 11'h001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !pwr_up) begin
      adc_cnt         <= 11'h000;
      adc_sample_tick <= 1'b0;
    end else begin
      adc_sample_tick <= 1'b0;
      if (conv_tick) begin
        if (adc_cnt >= adc_len - 11'h001) begin
          adc_cnt         <= 11'h000;
          adc_sample_tick <= 1'b1;
        end else begin
          adc_cnt <= adc_cnt + 11'h001;
        end
      end
    end
  end

  // ---------------- word clocks and first general pin ----------------
  // square word clocks, high for the first half of each frame
  logic pll_out_clk;

  // dac frame sync on word clock, adc sync separate only when rates differ
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dac_frame_sync <= 1'b0;
      adc_frame_sync <= 1'b0;
    end else begin
      dac_frame_sync <= pwr_up && dac_cnt < (dac_len >> 1);
      adc_frame_sync <= pwr_up && (rates_differ ? adc_cnt < (adc_len >> 1)
                                                : dac_cnt < (dac_len >> 1));
    end
  end

  // the pll output is shown as a square wave at half the tick rate
  always_ff @(posedge clk) begin
    if (sys_rst || !pll_en || pwr_up) begin
      pll_out_clk <= 1'b0;
    end else if (pll_fire) begin
      pll_out_clk <= ~pll_out_clk;
    end
  end

  // pll clock out when powered down
  // adc sync driven when rates differ
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      general_io_one_out <= 1'b0;
      general_io_one_oe  <= 1'b0;
    end else if (!pwr_up) begin
      general_io_one_out <= pll_out_clk;
      general_io_one_oe  <= pll_en;
    end else begin
      general_io_one_out <= adc_frame_sync;
      general_io_one_oe  <= rates_differ;
    end
  end

  // input side of the shared pin is not used for timing in master operation
  logic unused_in;
  assign unused_in = general_io_one_in;

endmodule
`default_nettype wire

// ===== bench/acg_rate_gen_properties.sv
// port checker for the audio clock rate generator
`timescale 1ns/10ps
`default_nettype none
module acg_rate_gen_props
  import acg_pkg::*;
(
  // system
  input wire logic        clk,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // timing
  input wire logic        master_tick,
  input wire logic        fs_ref_tick,
  input wire logic        dac_sample_tick,
  input wire logic        adc_sample_tick
);
  logic [2:0]  mark;
  logic [2:0]  arm;
  logic [11:0] cnt [3];
  logic [11:0] tot [3];
  logic        mapped;
  assign mark = {adc_sample_tick, dac_sample_tick, fs_ref_tick};
  assign mapped = paddr inside {ADDR_CTRL, ADDR_PLL_A, ADDR_PLL_D, ADDR_DIV, ADDR_STATUS,
                                ADDR_CLK_SRC};
  // master ticks since the last mark; the first mark after reset only arms the count
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (sys_rst) begin
        cnt[i] <= '0;
        arm[i] <= 1'b0;
      end else if (mark[i]) begin
        cnt[i] <= '0;
        arm[i] <= 1'b1;
      end else begin
        cnt[i] <= cnt[i] + 12'(master_tick);
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      tot[i] = cnt[i] + 12'(master_tick);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_READY: assert property (pready)
    else $error("pready dropped");
  AST_ERR_MAP: assert property (psel && !penable |=> pslverr == !$past(mapped))
    else $error("slave error does not follow the address map");
  AST_ERR_ZERO: assert property (psel && penable && !pwrite && pslverr |-> prdata == '0)
    else $error("unmapped read returned data");
  AST_FS_256: assert property (fs_ref_tick && arm[0] |-> tot[0] == 12'h100)
    else $error("frame does not hold 256 master ticks");
  AST_FS_PULSE: assert property (fs_ref_tick |=> !fs_ref_tick)
    else $error("frame tick longer than one cycle");
  AST_DAC_RATIO: assert property (dac_sample_tick && arm[1] |->
    tot[1][5:0] == 6'h00 && tot[1] inside {[12'h080:12'h600]})
    else $error("dac sample period off the divisor grid");
  AST_ADC_RATIO: assert property (adc_sample_tick && arm[2] |->
    tot[2][5:0] == 6'h00 && tot[2] inside {[12'h080:12'h600]})
    else $error("adc sample period off the divisor grid");
  AST_DAC_PULSE: assert property ($rose(dac_sample_tick) |=> $fell(dac_sample_tick))
    else $error("dac tick longer than one cycle");
  AST_ADC_PULSE: assert property (adc_sample_tick |=> !adc_sample_tick [*2])
    else $error("adc ticks too close");
endmodule
`default_nettype wire

// ===== bench/acg_clk_src.sv
// external clock source model for the master, bit and second general pins
`timescale 1ns/10ps
`default_nettype none
module acg_clk_src #(
  parameter int unsigned MCLK_HALF = 40,
  parameter int unsigned BCLK_HALF = 36,
  parameter int unsigned GIO2_HALF = 52
) (
  // control
  input  wire logic run,
  // pins
  output logic      mclk_pin,
  output logic      bclk_pin,
  output logic      general_io_two_pin
);
  // master clock in band
  // 12.5 MHz: inside the band, below what 125 MHz edge detection can follow
  initial begin
    mclk_pin = 1'b0;
    forever #(MCLK_HALF) mclk_pin = run ? ~mclk_pin : 1'b0;
  end
  initial begin
    bclk_pin = 1'b0;
    forever #(BCLK_HALF) bclk_pin = run ? ~bclk_pin : 1'b0;
  end
  initial begin
    general_io_two_pin = 1'b0;
    forever #(GIO2_HALF) general_io_two_pin = run ? ~general_io_two_pin : 1'b0;
  end
endmodule
`default_nettype wire

// ===== bench/acg_rate_gen_bench.sv
// self-checking bench for the audio clock rate generator
`timescale 1ns/10ps
`default_nettype none
module acg_rate_gen_bench;
  import acg_pkg::*;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, run, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        mclk_pin, bclk_pin, general_io_two_pin, gio1_out, gio1_oe, gio1_wire;
  logic        master_tick, fs_ref_tick, dac_sample_tick, adc_sample_tick, dac_fs, adc_fs;
  int          fail_count, num_checks, n, k, m;
  logic [1:0]  dsrc [4] = '{SRC_MCLK, SRC_BCLK, SRC_GIO2, SRC_MCLK};
  int          dq [4] = '{2, 3, 2, 17};
  int          dper [4] = '{80, 72, 104, 80};
  assign gio1_wire = gio1_oe ? gio1_out : 1'b0;
  acg_rate_gen acg_rate_gen_i (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mclk_pin(mclk_pin), .bclk_pin(bclk_pin), .general_io_two_pin(general_io_two_pin),
    .general_io_one_in(gio1_wire), .general_io_one_out(gio1_out),
    .general_io_one_oe(gio1_oe), .master_tick(master_tick), .fs_ref_tick(fs_ref_tick),
    .dac_sample_tick(dac_sample_tick), .adc_sample_tick(adc_sample_tick),
    .dac_frame_sync(dac_fs), .adc_frame_sync(adc_fs));
  acg_clk_src acg_clk_src_i (
    .run(run), .mclk_pin(mclk_pin), .bclk_pin(bclk_pin),
    .general_io_two_pin(general_io_two_pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input longint got, input longint exp, input longint tol);
    num_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("[ERR] %0t span %0d ns expected %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, e});
  endtask
  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  // power up, then time the first reference frame
  task automatic fs_time(input logic [31:0] ctrl, input longint exp, input longint tol);
    time t0;
    apb(1'b1, ADDR_CTRL, ctrl);
    t0 = $time;
    k  = 0;
    while (fs_ref_tick !== 1'b1 && k < 40000) begin
      @(negedge clk);
      k++;
    end
    chk_near(longint'($time - t0), exp, tol);
  endtask
  // master ticks from one sample tick to the next
  task automatic span(input logic adc, output int cnt);
    cnt = 0;
    k   = 0;
    while ((adc ? adc_sample_tick : dac_sample_tick) !== 1'b1 && k < 40000) begin
      @(negedge clk);
      k++;
    end
    do begin
      @(negedge clk);
      cnt += int'(master_tick === 1'b1);
      k++;
    end while ((adc ? adc_sample_tick : dac_sample_tick) !== 1'b1 && k < 40000);
  endtask
  task automatic pll_case(input logic [1:0] src, input int p, r, j, d, per);
    do_reset();
    apb(1'b1, ADDR_CLK_SRC, 32'(src) << PLLSRC_LSB);
    apb(1'b1, ADDR_PLL_A, 32'(p | (r << PLL_R_LSB) | (j << PLL_J_LSB)));
    apb(1'b1, ADDR_PLL_D, 32'(d));
    fs_time(32'h3, longint'(2048) * 10000 * p * per / ((j * 10000 + d) * r), per + 48);
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, run} = 5'h10;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    fail_count = 0;
    num_checks = 0;
    do_reset();
    rd_chk(ADDR_CLK_SRC, 32'h0000_0000, 1'b0);
    rd_chk(ADDR_PLL_A, 32'h0000_1011, 1'b0);
    rd_chk(ADDR_PLL_D, 32'h0000_0780, 1'b0);
    rd_chk(ADDR_DIV, 32'h0000_2202, 1'b0);
    rd_chk(ADDR_CTRL, 32'h0000_0000, 1'b0);
    apb(1'b1, ADDR_STATUS, 32'h0000_000f);
    rd_chk(ADDR_STATUS, 32'h0000_0000, 1'b0);
    apb(1'b1, 12'h1fc, 32'h0000_00ff);
    rd_chk(12'h1fc, 32'h0000_0000, 1'b1);
    apb(1'b1, ADDR_CLK_SRC, 32'h0000_0090);
    rd_chk(ADDR_CLK_SRC, 32'h0000_0090, 1'b0);
    apb(1'b1, ADDR_PLL_D, 32'h0000_270f);
    rd_chk(ADDR_PLL_D, 32'h0000_270f, 1'b0);
    $display("registers test done");
    run = 1'b1;
    foreach (dsrc[i]) begin
      do_reset();
      apb(1'b1, ADDR_CLK_SRC, 32'(dsrc[i]) << DIVSRC_LSB);
      apb(1'b1, ADDR_DIV, 32'h0000_2200 | 32'(dq[i]));
      fs_time(32'h2, 128 * dq[i] * dper[i], dper[i] + 48);
      chk({31'h0, gio1_oe}, 32'h0);
    end
    $display("divider test done");
    pll_case(SRC_MCLK, 1, 1, 7, 5264, 80);
    pll_case(SRC_BCLK, 2, 2, 7, 0, 72);
    $display("pll test done");
    do_reset();
    // even divider keeps the half-step dac divisor legal
    apb(1'b1, ADDR_DIV, 32'h0000_c302);
    apb(1'b1, ADDR_CTRL, 32'h0000_0006);
    span(1'b0, n);
    chk(32'(n), 32'(3 * 64));
    // one dac frame of 192 ticks at 10 cycles each: word clock high for half
    m = 0;
    n = 0;
    repeat (1920) begin
      @(negedge clk);
      m += int'(dac_fs === 1'b1);
      n += int'(adc_fs !== dac_fs);
    end
    chk_near(m, 960, 20);
    chk(32'(n > 0), 32'h1);
    span(1'b1, n);
    chk(32'(n), 32'(12 * 128));
    chk({31'h0, gio1_oe}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h0000_000c, 32'h0000_000c);
    $display("sample rate test done");
    do_reset();
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    n = 0;
    k = 0;
    repeat (4000) begin
      @(negedge clk);
      n += int'(gio1_out === 1'b1);
      k += int'(master_tick === 1'b1);
    end
    chk({31'h0, gio1_oe}, 32'h1);
    chk(32'(n > 0 && n < 4000), 32'h1);
    chk(32'(k), 32'h0);
    $display("pass-through test done");
    wrap_up();
  end
  initial begin
    repeat (98000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
bind acg_rate_gen acg_rate_gen_props acg_rate_gen_props_i (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .master_tick(master_tick), .fs_ref_tick(fs_ref_tick),
  .dac_sample_tick(dac_sample_tick), .adc_sample_tick(adc_sample_tick));
`default_nettype wire
